/* sfr_map_core_regs.sv */
// Purpose: generic core special function register bank
// Assumes: core drives one byte or bit access per cycle on the internal path
// Notes: read data is registered, one cycle after the strobe
`default_nettype none
module sfr_map_core_regs
   import sfr_core_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register access path
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWriteData,
   input wire logic bitAccess,
   input wire logic [2:0] bitIndex,
   input wire logic bitValue,
   output logic [7:0] sfrReadData,
   output logic sfrHit,
   // core execution side effects
   input wire logic stackPush,
   input wire logic stackPop,
   input wire logic accLoad,
   input wire logic [7:0] accLoadData,
   input wire logic flagLoad,
   input wire logic carryIn,
   input wire logic halfCarryIn,
   input wire logic signedWrapIn,
   input wire logic mulDivLoad,
   input wire logic [7:0] mulDivResult,
   // decoded views for the core
   output logic [7:0] stackPointer,
   output logic [7:0] stackWriteAddr,
   output logic [15:0] activeDataPointer,
   output logic [7:0] pagedXdataHigh,
   output logic [7:0] bankBase,
   output logic [7:0] accumulator,
   output logic [7:0] multiplyDivideAux,
   output logic [7:0] programStatusWord,
   output logic [1:0] extIrqPolarity,
   output logic baudRateSel,
   output logic [7:0] port0Latch,
   output logic [2:0] memoryStretch
);
   timeunit 1ns;
   timeprecision 1ps;
   // address and reset tables, one entry per implemented register
   localparam logic [7:0] ADDR_TAB [NUM_REGS] = '{
      ADDR_PORT0, ADDR_SP, ADDR_DP0L, ADDR_DP0H, ADDR_DP1L, ADDR_DP1H, ADDR_PWRCTL,
      ADDR_TCTL, ADDR_TMODE, ADDR_T0L, ADDR_T1L, ADDR_T0H, ADDR_T1H, ADDR_STRETCH,
      ADDR_PSEL, ADDR_SER0CTL, ADDR_SER0BUF, ADDR_IRQ_ENABLE_2, ADDR_SER1CTL, ADDR_SER1BUF,
      ADDR_SER1RLL, ADDR_IRQ_ENABLE_0, ADDR_IPRI0, ADDR_SER0RLL, ADDR_IRQ_ENABLE_1, ADDR_IPRI1,
      ADDR_SER0RLH, ADDR_SER1RLH, ADDR_PAGEHI, ADDR_IRQREQ, ADDR_XPOL, ADDR_STATUS,
      ADDR_BAUD, ADDR_ACCUM, ADDR_AUXREG};
   localparam logic [7:0] RST_TAB [NUM_REGS] = '{
      RST_PORT0, RST_SP, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
      RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_STRETCH,
      RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
      RST_ZERO, RST_ZERO, RST_ZERO, RST_SER0RLL, RST_ZERO, RST_ZERO,
      RST_RLH, RST_RLH, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
      RST_ZERO, RST_ZERO, RST_ZERO};
   // indices of registers the core itself touches
   localparam int IX_PORT0 = 0;
   localparam int IX_SP = 1;
   localparam int IX_DP0L = 2;
   localparam int IX_DP0H = 3;
   localparam int IX_DP1L = 4;
   localparam int IX_DP1H = 5;
   localparam int IX_STRETCH = 13;
   localparam int IX_PSEL = 14;
   localparam int IX_PAGEHI = 28;
   localparam int IX_XPOL = 30;
   localparam int IX_STATUS = 31;
   localparam int IX_BAUD = 32;
   localparam int IX_ACCUM = 33;
   localparam int IX_AUXREG = 34;

   logic [7:0] regFile_reg [NUM_REGS];
   logic [7:0] regFile_next [NUM_REGS];
   logic [7:0] readData_reg;
   logic [7:0] readData_next;
   logic hit_reg;

   // bit access legal only on rows whose low address bits are clear
   wire logic bitRow = (sfrAddr[2:0] == BITROW_LOW);
   wire logic bitWrite = bitAccess & bitRow;
   wire logic bitRefused = bitAccess & ~bitRow;

   // per register address match
   logic [NUM_REGS-1:0] match;
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : gMatch
         assign match[g] = (sfrAddr == ADDR_TAB[g]);
      end
   endgenerate
   wire logic anyMatch = |match;

   // merged write value of the addressed register
   logic [7:0] selOld;
   logic [7:0] mergedData;
   always_comb begin
      selOld = UNMAPPED_DATA;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (match[i]) begin
            selOld = regFile_reg[i];
         end
      end
   end
   sfr_bit_merge uMerge (
      .oldValue(selOld),
      .writeData(sfrWriteData),
      .bitAccess(bitWrite),
      .bitIndex(bitIndex),
      .bitValue(bitValue),
      .newValue(mergedData)
   );

   // accumulator after this cycle, used for parity
   wire logic accWrite = sfrWrite & ~bitRefused & match[IX_ACCUM];
   wire logic [7:0] accNext = accLoad ? accLoadData : (accWrite ? mergedData : regFile_reg[IX_ACCUM]);
   logic parityOdd;
   sfr_parity uParity (
      .value(accNext),
      .odd(parityOdd)
   );

   // next value of every register; software write first, core updates win
   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         regFile_next[i] = regFile_reg[i];
         if (sfrWrite && !bitRefused && match[i]) begin
            regFile_next[i] = mergedData;
         end
      end
      // only the top bit of baud control exists
      regFile_next[IX_BAUD] = regFile_next[IX_BAUD] & BAUD_MASK;
      // pre-increment on push, post-decrement on pop
      if (stackPush && !stackPop) begin
         regFile_next[IX_SP] = regFile_reg[IX_SP] + 8'h01;
      end else if (stackPop && !stackPush) begin
         regFile_next[IX_SP] = regFile_reg[IX_SP] - 8'h01;
      end
      if (accLoad) begin
         regFile_next[IX_ACCUM] = accLoadData;
      end
      if (mulDivLoad) begin
         regFile_next[IX_AUXREG] = mulDivResult;
      end
      // arithmetic flags from the core override software
      if (flagLoad) begin
         regFile_next[IX_STATUS][PSW_CARRY] = carryIn;
         regFile_next[IX_STATUS][PSW_HALF] = halfCarryIn;
         regFile_next[IX_STATUS][PSW_WRAP] = signedWrapIn;
      end
      // parity is never software writable; it tracks the accumulator
      regFile_next[IX_STATUS][PSW_PARITY] = parityOdd;
   end

   // read mux; unmapped reads give a fixed filler value
   always_comb begin
      readData_next = readData_reg;
      if (sfrRead) begin
         readData_next = anyMatch ? selOld : UNMAPPED_DATA;
      end
   end

   // register storage
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regFile_reg[i] <= RST_TAB[i];
         end
         readData_reg <= RST_ZERO;
         hit_reg <= 1'b0;
      end else begin
         regFile_reg <= regFile_next;
         readData_reg <= readData_next;
         hit_reg <= (sfrRead | sfrWrite) & anyMatch & ~bitRefused;
      end
   end

   // registered views; each output is a flip-flop
   logic [7:0] spOut_reg;
   logic [7:0] stackAddr_reg;
   logic [15:0] dptr_reg;
   logic [7:0] bank_reg;
   always_ff @(posedge clock) begin
      if (reset) begin
         spOut_reg <= RST_SP;
         stackAddr_reg <= RST_SP + 8'h01;
         dptr_reg <= 16'h0000;
         bank_reg <= 8'h00;
      end else begin
         spOut_reg <= regFile_next[IX_SP];
         stackAddr_reg <= regFile_next[IX_SP] + 8'h01;
         // selection never disturbs pointer contents
         dptr_reg <= regFile_next[IX_PSEL][PSEL_BIT] ?
            {regFile_next[IX_DP1H], regFile_next[IX_DP1L]} :
            {regFile_next[IX_DP0H], regFile_next[IX_DP0L]};
         // bank base is bank times eight
         bank_reg <= {3'h0, regFile_next[IX_STATUS][PSW_BANKHI],
            regFile_next[IX_STATUS][PSW_BANKLO], 3'h0};
      end
   end

   // outputs
   assign sfrReadData = readData_reg;
   assign sfrHit = hit_reg;
   assign stackPointer = spOut_reg;
   assign stackWriteAddr = stackAddr_reg;
   assign activeDataPointer = dptr_reg;
   assign bankBase = bank_reg;
   assign pagedXdataHigh = regFile_reg[IX_PAGEHI];
   assign accumulator = regFile_reg[IX_ACCUM];
   assign multiplyDivideAux = regFile_reg[IX_AUXREG];
   // user flags bits five and one are stored only, no hardware use
   assign programStatusWord = regFile_reg[IX_STATUS];
   assign extIrqPolarity = regFile_reg[IX_XPOL][1:0];
   assign baudRateSel = regFile_reg[IX_BAUD][BAUD_BIT];
   assign port0Latch = regFile_reg[IX_PORT0];
   assign memoryStretch = regFile_reg[IX_STRETCH][2:0];
endmodule : sfr_map_core_regs
`default_nettype wire

/* sfr_core_pkg.sv */
// Purpose: constants for the core special function register bank
// Assumes: 8-bit register space at 0x80..0xFF, one clock
// Notes: offsets are byte addresses inside the register space
`default_nettype none
package sfr_core_pkg;
   timeunit 1ns;
   timeprecision 1ps;
   // register offsets
   localparam logic [7:0] ADDR_PORT0 = 8'h80;
   localparam logic [7:0] ADDR_SP = 8'h81;
   localparam logic [7:0] ADDR_DP0L = 8'h82;
   localparam logic [7:0] ADDR_DP0H = 8'h83;
   localparam logic [7:0] ADDR_DP1L = 8'h84;
   localparam logic [7:0] ADDR_DP1H = 8'h85;
   localparam logic [7:0] ADDR_PWRCTL = 8'h87;
   localparam logic [7:0] ADDR_TCTL = 8'h88;
   localparam logic [7:0] ADDR_TMODE = 8'h89;
   localparam logic [7:0] ADDR_T0L = 8'h8A;
   localparam logic [7:0] ADDR_T1L = 8'h8B;
   localparam logic [7:0] ADDR_T0H = 8'h8C;
   localparam logic [7:0] ADDR_T1H = 8'h8D;
   localparam logic [7:0] ADDR_STRETCH = 8'h8E;
   localparam logic [7:0] ADDR_PSEL = 8'h92;
   localparam logic [7:0] ADDR_SER0CTL = 8'h98;
   localparam logic [7:0] ADDR_SER0BUF = 8'h99;
   localparam logic [7:0] ADDR_IRQ_ENABLE_2 = 8'h9A;
   localparam logic [7:0] ADDR_SER1CTL = 8'h9B;
   localparam logic [7:0] ADDR_SER1BUF = 8'h9C;
   localparam logic [7:0] ADDR_SER1RLL = 8'h9D;
   localparam logic [7:0] ADDR_IRQ_ENABLE_0 = 8'hA8;
   localparam logic [7:0] ADDR_IPRI0 = 8'hA9;
   localparam logic [7:0] ADDR_SER0RLL = 8'hAA;
   localparam logic [7:0] ADDR_IRQ_ENABLE_1 = 8'hB8;
   localparam logic [7:0] ADDR_IPRI1 = 8'hB9;
   localparam logic [7:0] ADDR_SER0RLH = 8'hBA;
   localparam logic [7:0] ADDR_SER1RLH = 8'hBB;
   localparam logic [7:0] ADDR_PAGEHI = 8'hBF;
   localparam logic [7:0] ADDR_IRQREQ = 8'hC0;
   localparam logic [7:0] ADDR_XPOL = 8'hC8;
   localparam logic [7:0] ADDR_STATUS = 8'hD0;
   localparam logic [7:0] ADDR_BAUD = 8'hD8;
   localparam logic [7:0] ADDR_ACCUM = 8'hE0;
   localparam logic [7:0] ADDR_AUXREG = 8'hF0;
   localparam int NUM_REGS = 35;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PORT0 = 8'hFF;
   localparam logic [7:0] RST_SP = 8'h07;
   localparam logic [7:0] RST_STRETCH = 8'h01;
   localparam logic [7:0] RST_SER0RLL = 8'hD9;
   localparam logic [7:0] RST_RLH = 8'h03;
   // value returned for unmapped locations
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // bit addressable rows have the low three address bits clear
   localparam logic [2:0] BITROW_LOW = 3'h0;
   // status word fields
   localparam int PSW_CARRY = 7;
   localparam int PSW_HALF = 6;
   localparam int PSW_USER0 = 5;
   localparam int PSW_BANKHI = 4;
   localparam int PSW_BANKLO = 3;
   localparam int PSW_WRAP = 2;
   localparam int PSW_USER1 = 1;
   localparam int PSW_PARITY = 0;
   localparam logic [7:0] PSW_HW_MASK = 8'hC4;
   localparam int BAUD_BIT = 7;
   localparam logic [7:0] BAUD_MASK = 8'h80;
   localparam int PSEL_BIT = 0;
endpackage : sfr_core_pkg
`default_nettype wire

/* sfr_bit_merge.sv */
// Purpose: merge a byte or single bit write into a register value
// Assumes: bit index valid only for bit accesses
// Notes: purely combinational
`default_nettype none
module sfr_bit_merge
   import sfr_core_pkg::*;
(
   // current value and request
   input wire logic [7:0] oldValue,
   input wire logic [7:0] writeData,
   input wire logic bitAccess,
   input wire logic [2:0] bitIndex,
   input wire logic bitValue,
   // merged result
   output logic [7:0] newValue
);
   timeunit 1ns;
   timeprecision 1ps;
   // one lane per bit; only the addressed bit changes on a bit write
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gLane
         wire logic hit = (bitIndex == 3'(g));
         assign newValue[g] = bitAccess ? (hit ? bitValue : oldValue[g]) : writeData[g];
      end
   endgenerate
endmodule : sfr_bit_merge
`default_nettype wire

/* sfr_parity.sv */
// Purpose: even/odd parity of the accumulator
// Assumes: combinational, feeds the status word parity bit
// Notes: high when the count of ones is odd
`default_nettype none
module sfr_parity (
   // operand
   input wire logic [7:0] value,
   // result
   output logic odd
);
   timeunit 1ns;
   timeprecision 1ps;
   assign odd = ^value;
endmodule : sfr_parity
`default_nettype wire

/* sfr_map_core_regs_assertions.sv */
// Purpose: property checks on the core register bank ports
// Assumes: one clock, synchronous active-high reset
// Notes: answers land one cycle after the taking edge
`default_nettype none
module sfr_map_core_regs_chk
   import sfr_core_pkg::*;
(
   // clock, reset, access path and core side effects
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic bitAccess,
   input wire logic stackPush,
   input wire logic stackPop,
   input wire logic mulDivLoad,
   input wire logic [7:0] mulDivResult,
   // observed outputs
   input wire logic [7:0] sfrReadData,
   input wire logic sfrHit,
   input wire logic [7:0] stackPointer,
   input wire logic [7:0] stackWriteAddr,
   input wire logic [7:0] bankBase,
   input wire logic [7:0] accumulator,
   input wire logic [7:0] multiplyDivideAux,
   input wire logic [7:0] programStatusWord,
   input wire logic [7:0] port0Latch
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // reset loads, push steps and steady relations between status, accumulator and stack views
   chk_reset_loads: assert property ($fell(reset) |-> stackPointer == RST_SP && port0Latch == RST_PORT0)
      else $error("reset load wrong");
   chk_parity_track: assert property (programStatusWord[PSW_PARITY] == ^accumulator)
      else $error("parity flag wrong");
   chk_bank_base: assert property (bankBase == {3'h0, programStatusWord[4:3], 3'h0})
      else $error("bank base wrong");
   chk_stack_ahead: assert property (stackWriteAddr == stackPointer + 8'h01)
      else $error("stack write address wrong");
   chk_push_step: assert property (stackPush && !stackPop && !sfrWrite |=> stackPointer == $past(stackPointer) + 8'h01)
      else $error("push did not increment");
   // access answers and the aux load, one cycle after the strobe or load
   chk_unmapped_miss: assert property ((sfrRead || sfrWrite) && sfrAddr == 8'h86 |=> !sfrHit)
      else $error("unmapped access hit");
   chk_bit_row: assert property (sfrWrite && bitAccess && sfrAddr[2:0] != BITROW_LOW |=> !sfrHit)
      else $error("bit write off a row hit");
   chk_baud_bits: assert property (sfrRead && sfrAddr == ADDR_BAUD |=> sfrReadData[6:0] == 7'h00)
      else $error("baud spare bits set");
   chk_aux_load: assert property (mulDivLoad |=> multiplyDivideAux == $past(mulDivResult))
      else $error("aux load lost");
endmodule : sfr_map_core_regs_chk
bind sfr_map_core_regs sfr_map_core_regs_chk u_chk (.clock, .reset, .sfrAddr, .sfrWrite, .sfrRead, .bitAccess,
   .stackPush, .stackPop, .mulDivLoad, .mulDivResult, .sfrReadData, .sfrHit, .stackPointer, .stackWriteAddr,
   .bankBase, .accumulator, .multiplyDivideAux, .programStatusWord, .port0Latch);
`default_nettype wire

/* sfr_core_model.sv */
// Purpose: processor core model driving the register access path
// Assumes: one access or one core operation per call
// Notes: data lines show inverted data once released
`default_nettype none
module sfr_core_model (
   // clock
   input wire logic clock,
   // access path
   output logic [7:0] sfrAddr,
   output logic sfrWrite,
   output logic sfrRead,
   output logic [7:0] sfrWriteData,
   output logic bitAccess,
   output logic [2:0] bitIndex,
   output logic bitValue,
   input wire logic [7:0] sfrReadData,
   input wire logic sfrHit,
   // execution side effects, one-hot {mulDiv, flag, acc, pop, push}
   output logic [4:0] opSel,
   output logic [7:0] opData
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle core: no strobes
   initial begin
      {sfrAddr, sfrWrite, sfrRead, sfrWriteData, bitAccess, bitIndex, bitValue, opSel, opData} = '0;
   end
   // request held over the taking edge, answer read once settled
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, input logic b,
      input logic [2:0] i, output logic [7:0] rd, output logic hit);
      @(posedge clock);
      {sfrAddr, sfrWrite, sfrRead, sfrWriteData, bitAccess, bitIndex, bitValue} <= {a, w, !w, d, b, i, d[0]};
      @(posedge clock);
      {sfrWrite, sfrRead, sfrWriteData} <= {2'b00, ~d};
      #1;
      rd = sfrReadData;
      hit = sfrHit;
   endtask : access
   // one-cycle core operation pulse
   task automatic op(input logic [4:0] k, input logic [7:0] d);
      @(posedge clock);
      {opSel, opData} <= {k, d};
      @(posedge clock);
      {opSel, opData} <= {5'h00, ~d};
      #1;
   endtask : op
endmodule : sfr_core_model
`default_nettype wire

/* tb_sfr_map_core_regs.sv */
// Purpose: self-checking bench for the core register bank
// Assumes: core model issues one access at a time
// Notes: expectations come from reset table and status layout
`default_nettype none
module tb_sfr_map_core_regs
   import sfr_core_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, reset, sfrWrite, sfrRead, bitAccess, bitValue, sfrHit, baudRateSel, hit;
   logic [2:0] bitIndex, memoryStretch;
   logic [1:0] extIrqPolarity;
   logic [4:0] opSel;
   logic [15:0] activeDataPointer;
   logic [7:0] sfrAddr, sfrWriteData, sfrReadData, opData, stackPointer, stackWriteAddr, rd;
   logic [7:0] pagedXdataHigh, bankBase, accumulator, multiplyDivideAux, programStatusWord, port0Latch;
   int n_errors = 0;
   int n_tests = 0;
   sfr_core_model u_core (.clock, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData, .bitAccess, .bitIndex,
      .bitValue, .sfrReadData, .sfrHit, .opSel, .opData);
   sfr_map_core_regs u_dut (.clock, .reset, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData, .bitAccess, .bitIndex,
      .bitValue, .sfrReadData, .sfrHit, .stackPush(opSel[0]), .stackPop(opSel[1]), .accLoad(opSel[2]),
      .accLoadData(opData), .flagLoad(opSel[3]), .carryIn(opData[7]), .halfCarryIn(opData[6]),
      .signedWrapIn(opData[2]), .mulDivLoad(opSel[4]), .mulDivResult(opData), .stackPointer, .stackWriteAddr,
      .activeDataPointer, .pagedXdataHigh, .bankBase, .accumulator, .multiplyDivideAux, .programStatusWord,
      .extIrqPolarity, .baudRateSel, .port0Latch, .memoryStretch);
   // shared compare, write and read helpers
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_core.access(1'b1, a, d, 1'b0, 3'h0, rd, hit);
   endtask : wr
   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      u_core.access(1'b0, a, 8'h00, 1'b0, 3'h0, rd, hit);
      chk(what, rd, exp);
   endtask : rdc
   // nonzero reset loads plus a zero one, each a hit
   task automatic t_reset;
      logic [7:0] adr [7] = '{ADDR_PORT0, ADDR_SP, ADDR_STRETCH, ADDR_SER0RLL, ADDR_SER0RLH, ADDR_SER1RLH, ADDR_DP1H};
      logic [7:0] val [7] = '{8'hFF, 8'h07, 8'h01, 8'hD9, 8'h03, 8'h03, 8'h00};
      foreach (adr[k]) begin
         rdc("reset value", adr[k], val[k]);
         chk("hit", hit, 1'b1);
      end
      // looked at once settled, well clear of the releasing edge
      chk("stackWriteAddr", stackWriteAddr, 8'h08);
      chk("stretch", memoryStretch, 3'h1);
   endtask : t_reset
   task automatic t_stack;
      u_core.op(5'h01, 8'h00);
      chk("push sp", stackPointer, 8'h08);
      u_core.op(5'h02, 8'h00);
      chk("pop sp", stackPointer, 8'h07);
   endtask : t_stack
   // an unmapped write must leave the next register alone
   task automatic t_unmapped;
      wr(8'h86, 8'h5A);
      chk("unmapped hit", hit, 1'b0);
      rdc("unmapped", 8'h86, UNMAPPED_DATA);
      rdc("next reg", ADDR_PWRCTL, 8'h00);
   endtask : t_unmapped
   task automatic t_bits;
      u_core.access(1'b1, ADDR_PORT0, 8'h00, 1'b1, 3'h3, rd, hit);
      chk("port0", port0Latch, 8'hF7);
      u_core.access(1'b1, ADDR_SP, 8'h00, 1'b1, 3'h0, rd, hit);
      chk("bit hit", hit, 1'b0);
      rdc("sp kept", ADDR_SP, 8'h07);
   endtask : t_bits
   // bank codes, user flags, parity and core flag loads
   task automatic t_psw;
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_STATUS, 8'(c << 3));
         chk("bank", bankBase, 8'(c * 8));
      end
      wr(ADDR_STATUS, 8'h23);
      rdc("user flags", ADDR_STATUS, 8'h22);
      wr(ADDR_ACCUM, 8'h07);
      chk("parity", programStatusWord, 8'h23);
      u_core.op(5'h04, 8'h0F);
      chk("acc", accumulator, 8'h0F);
      chk("parity even", programStatusWord, 8'h22);
      u_core.op(5'h08, 8'h84);
      chk("flags", programStatusWord, 8'hA6);
      u_core.op(5'h08, 8'h40);
      chk("half carry", programStatusWord, 8'h62);
   endtask : t_psw
   task automatic t_misc;
      wr(ADDR_AUXREG, 8'h5A);
      rdc("aux", ADDR_AUXREG, 8'h5A);
      u_core.op(5'h10, 8'h3C);
      chk("aux load", multiplyDivideAux, 8'h3C);
      wr(ADDR_BAUD, 8'hFF);
      rdc("baud", ADDR_BAUD, 8'h80);
      chk("baud sel", baudRateSel, 1'b1);
      wr(ADDR_PAGEHI, 8'hA5);
      chk("paged", pagedXdataHigh, 8'hA5);
      wr(ADDR_XPOL, 8'h02);
      chk("polarity", extIrqPolarity, 2'h2);
   endtask : t_misc
   // toggling the select must not disturb either pair
   task automatic t_pointer;
      wr(ADDR_DP0L, 8'h34);
      wr(ADDR_DP0H, 8'h12);
      wr(ADDR_DP1L, 8'hCD);
      wr(ADDR_DP1H, 8'hAB);
      for (int s = 0; s < 3; s++) begin
         wr(ADDR_PSEL, 8'(s & 1));
         chk("pointer", activeDataPointer, (s & 1) ? 16'hABCD : 16'h1234);
      end
      rdc("dp1 high", ADDR_DP1H, 8'hAB);
   endtask : t_pointer
   // mid-run reset of one edge must restore values written over above
   task automatic t_rereset;
      @(posedge clock);
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      #1;
      chk("re port0", port0Latch, 8'hFF);
      chk("re sp", stackPointer, 8'h07);
      chk("re paged", pagedXdataHigh, 8'h00);
      chk("re pointer", activeDataPointer, 16'h0000);
      chk("re baud", baudRateSel, 1'b0);
      chk("re stretch", memoryStretch, 3'h1);
      rdc("re reload", ADDR_SER0RLL, 8'hD9);
   endtask : t_rereset
   task automatic end_sim;
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   // clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // watchdog, far beyond the hundred or so cycles needed
   initial begin
      #20000;
      n_errors++;
      end_sim();
   end
   // main sequence
   initial begin
      reset = 1'b1;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_stack();
      t_unmapped();
      t_bits();
      t_psw();
      t_misc();
      t_pointer();
      t_rereset();
      end_sim();
   end
endmodule : tb_sfr_map_core_regs
`default_nettype wire
